// >>> servo_block_master.sv
// Controller end: software fills a command block over APB and sends it; the response is captured.
// Assumes APB is synchronous to clk and the unit answers each block with one response.
module servo_block_master (
  input  wire logic         clk,
  input  wire logic         rstn,
  servo_link_if.master_end  link,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  output logic              irq
);

  typedef struct packed {
    logic [7:0]  cmd_ctrl;
    logic [55:0] cmd_data;
    logic        tx_busy;
    logic [2:0]  tx_idx;
    logic [63:0] tx_buf;
    logic        cmd_valid;
    logic        cmd_first;
    logic [7:0]  cmd_byte;
    logic [2:0]  rx_idx;
    logic [63:0] rx_buf;
    logic [63:0] rsp;
    logic [1:0]  int_status;
    logic [1:0]  int_mask;
    logic        irq;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } master_state_s;

  master_state_s s;
  master_state_s next_s;

  always_comb begin
    logic        wr;
    logic        done;
    logic [1:0]  ev;
    logic [1:0]  clr;
    logic [63:0] nb;
    wr   = psel & penable & s.pready & pwrite;
    done = 1'b0;
    ev   = 2'h0;
    clr  = 2'h0;
    nb   = s.rx_buf;
    next_s = s;

    // Zero-wait slave: answer is registered in the setup cycle, taken in the access cycle.
    next_s.pready  = psel & !penable;
    next_s.pslverr = 1'b0;
    next_s.prdata  = 32'h0;
    if (psel && !penable) begin
      if (!pwrite) begin
        case (paddr)
          servo_block_pkg::OFF_CMD_CTRL:    next_s.prdata = {24'h0, s.cmd_ctrl};
          servo_block_pkg::OFF_CMD_DATA_LO: next_s.prdata = s.cmd_data[31:0];
          servo_block_pkg::OFF_CMD_DATA_HI: next_s.prdata = {8'h0, s.cmd_data[55:32]};
          servo_block_pkg::OFF_SEND:        next_s.prdata = {31'h0, s.tx_busy};
          servo_block_pkg::OFF_RSP_LO:      next_s.prdata = s.rsp[31:0];
          servo_block_pkg::OFF_RSP_HI:      next_s.prdata = s.rsp[63:32];
          servo_block_pkg::OFF_INT_STATUS:  next_s.prdata = {30'h0, s.int_status};
          servo_block_pkg::OFF_INT_MASK:    next_s.prdata = {30'h0, s.int_mask};
          default:                          next_s.pslverr = 1'b1;
        endcase
      end else begin
        case (paddr)
          servo_block_pkg::OFF_CMD_CTRL, servo_block_pkg::OFF_CMD_DATA_LO,
          servo_block_pkg::OFF_CMD_DATA_HI, servo_block_pkg::OFF_SEND,
          servo_block_pkg::OFF_INT_STATUS, servo_block_pkg::OFF_INT_MASK: next_s.pslverr = 1'b0;
          default:                          next_s.pslverr = 1'b1;
        endcase
      end
    end

    // Software must cure the fault cause before setting fault clear.
    if (wr) begin
      case (paddr)
        servo_block_pkg::OFF_CMD_CTRL:    next_s.cmd_ctrl = pwdata[7:0] & servo_block_pkg::CMD0_WRITABLE;
        servo_block_pkg::OFF_CMD_DATA_LO: next_s.cmd_data[31:0] = pwdata;
        servo_block_pkg::OFF_CMD_DATA_HI: next_s.cmd_data[55:32] = pwdata[23:0];
        servo_block_pkg::OFF_INT_STATUS:  clr = pwdata[1:0];
        servo_block_pkg::OFF_INT_MASK:    next_s.int_mask = pwdata[1:0] & servo_block_pkg::INT_BITS;
        default:                          clr = 2'h0;
      endcase
    end

    // Sender: control byte and data leave as one snapshot, so data never lags launch.
    if (s.tx_busy) begin
      next_s.cmd_valid = 1'b1;
      next_s.cmd_first = (s.tx_idx == 3'h0);
      next_s.cmd_byte  = s.tx_buf[{s.tx_idx, 3'b000} +: 8];
      next_s.tx_idx    = s.tx_idx + 3'h1;
      next_s.tx_busy   = (s.tx_idx != servo_block_pkg::LAST_BYTE);
    end else begin
      next_s.cmd_valid = 1'b0;
      next_s.cmd_first = 1'b0;
      next_s.cmd_byte  = 8'h00;
      if (wr && paddr == servo_block_pkg::OFF_SEND && pwdata[0]) begin
        next_s.tx_busy = 1'b1;
        next_s.tx_idx  = 3'h0;
        next_s.tx_buf  = {s.cmd_data, s.cmd_ctrl};
        // A fault clear is requested once; the bit then drops back to idle.
        next_s.cmd_ctrl[servo_block_pkg::BIT_FAULT_CLEAR] = 1'b0;
      end
    end

    // Response collector.
    if (link.rsp_valid) begin
      if (link.rsp_first) begin
        next_s.rx_buf[7:0] = link.rsp_byte;
        next_s.rx_idx      = 3'h1;
      end else if (s.rx_idx != 3'h0) begin
        next_s.rx_buf[{s.rx_idx, 3'b000} +: 8] = link.rsp_byte;
        next_s.rx_idx = s.rx_idx + 3'h1;
        if (s.rx_idx == servo_block_pkg::LAST_BYTE) begin
          done = 1'b1;
          nb[63:56] = link.rsp_byte;
        end
      end
    end
    if (done) begin
      next_s.rsp = nb;
      ev[servo_block_pkg::INT_RSP_DONE] = 1'b1;
      ev[servo_block_pkg::INT_HALT_REPORTED] = nb[servo_block_pkg::RBIT_HALTED] &
                                               !s.rsp[servo_block_pkg::RBIT_HALTED];
    end

    next_s.int_status = ev | (s.int_status & ~clr);
    next_s.irq = |(next_s.int_status & next_s.int_mask);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.cmd_ctrl <= servo_block_pkg::RST_CMD_CTRL;
    end else begin
      s <= next_s;
    end
  end

  assign link.cmd_valid = s.cmd_valid;
  assign link.cmd_first = s.cmd_first;
  assign link.cmd_byte  = s.cmd_byte;
  assign prdata         = s.prdata;
  assign pready         = s.pready;
  assign pslverr        = s.pslverr;
  assign irq            = s.irq;

endmodule : servo_block_master

// >>> servo_block_pkg.sv
// Shared constants for the servo command block link and its controller.
// Assumes both ends run on one 125 MHz clock and exchange bytes one per cycle.
package servo_block_pkg;
  localparam int unsigned BLOCK_BYTES          = 8;
  localparam logic [2:0]  LAST_BYTE            = 3'h7;
  // Bit positions in command byte 0.
  localparam int unsigned BIT_BLOCK_SELECT     = 7;
  localparam int unsigned BIT_FAULT_CLEAR      = 5;
  localparam int unsigned BIT_HALT_PERMIT      = 4;
  localparam int unsigned BIT_DRIVE_ENABLE     = 1;
  localparam int unsigned BIT_COMMAND_LAUNCH   = 0;
  localparam logic [7:0]  CMD0_WRITABLE        = 8'hb3;
  // Bit positions in response byte 0.
  localparam int unsigned RBIT_READY           = 6;
  localparam int unsigned RBIT_MAIN_POWER      = 5;
  localparam int unsigned RBIT_HALTED          = 4;
  localparam int unsigned RBIT_ALARM           = 3;
  localparam int unsigned RBIT_WARNING         = 2;
  localparam int unsigned RBIT_DRIVE_ON        = 1;
  // Controller register map, one aligned word each.
  localparam logic [7:0]  OFF_CMD_CTRL         = 8'h00;
  localparam logic [7:0]  OFF_CMD_DATA_LO      = 8'h04;
  localparam logic [7:0]  OFF_CMD_DATA_HI      = 8'h08;
  localparam logic [7:0]  OFF_SEND             = 8'h0c;
  localparam logic [7:0]  OFF_RSP_LO           = 8'h10;
  localparam logic [7:0]  OFF_RSP_HI           = 8'h14;
  localparam logic [7:0]  OFF_INT_STATUS       = 8'h18;
  localparam logic [7:0]  OFF_INT_MASK         = 8'h1c;
  // Interrupt status bits.
  localparam int unsigned INT_RSP_DONE         = 0;
  localparam int unsigned INT_HALT_REPORTED    = 1;
  localparam logic [1:0]  INT_BITS             = 2'h3;
  // Reset values: the halt permit idles high so a fresh controller requests no stop.
  localparam logic [7:0]  RST_CMD_CTRL         = 8'h10;
  localparam logic [63:0] RST_HELD_BLOCK       = 64'h0;
endpackage : servo_block_pkg

// >>> servo_command_block_decoder.sv
// Servo unit end: collects 8-byte command blocks, decodes byte 0, frames the response.
// Assumes the link bytes are synchronous to clk and the drive side reports motion state.
// Assumes the master keeps at most one command block in flight at a time.
// How it works
// - Command and response blocks are exactly eight bytes.
// - Byte 0 controls; bytes 1-7 are data.
// - Command type comes only from byte 0 bit 7.
// - Byte 0 bit layout, reserved bits zero.
// - Block select chooses move or set/read decode.
// - Fault clear request clears alarm and warning.
// - Master removes fault cause before clearing.
// - Master keeps fault clear low normally.
// - Halt permit falling aborts move, drive off.
// - Moving axis stops now; drive off at rest.
// - Master holds halt permit high normally.
// - Stay halted while halt permit is low.
// - Leave halt when halt permit returns high.
// - After halt, re-enable needs enable low-then-high.
// - Drive follows enable request edges and level.
// - Master sets data no later than launch.
// - Response bit 7 echoes block select.
// - Response halt flag mirrors low halt permit.
//
// The APB slave port and the register offsets are this design's own decisions.
module servo_command_block_decoder (
  input  wire logic         clk,
  input  wire logic         rstn,
  servo_link_if.unit_end    link,
  input  wire logic         motor_at_rest,
  input  wire logic         main_power_on,
  input  wire logic         alarm_event,
  input  wire logic         warning_event,
  input  wire logic [55:0]  response_data,
  output logic              drive_on,
  output logic              halt_travel,
  output logic              move_abort,
  output logic              move_launch,
  output logic              setread_launch,
  output logic              fault_clear_pulse,
  output logic              data_is_setread,
  output logic [55:0]       command_data
);

  typedef struct packed {
    logic [2:0]  rx_idx;
    logic [63:0] rx_buf;
    logic [63:0] held;
    logic        halted;
    logic        need_rearm;
    logic        drive_on;
    logic        alarm;
    logic        warn;
    logic        move_abort;
    logic        move_launch;
    logic        setread_launch;
    logic        fault_clear;
    logic        tx_busy;
    logic [2:0]  tx_idx;
    logic [63:0] tx_buf;
    logic        rsp_valid;
    logic        rsp_first;
    logic [7:0]  rsp_byte;
  } unit_state_s;

  unit_state_s s;
  unit_state_s next_s;

  always_comb begin
    logic        complete;
    logic [63:0] nb;
    logic [7:0]  old0;
    logic [7:0]  new0;
    logic        clear_req;
    logic        setread_sel;
    logic        permit_low;
    logic        enable_rise;
    logic        launch_rise;
    logic        drive_allowed;
    logic [7:0]  status0;
    complete      = 1'b0;
    nb            = s.rx_buf;
    old0          = s.held[7:0];
    new0          = 8'h00;
    clear_req     = 1'b0;
    setread_sel   = 1'b0;
    permit_low    = 1'b0;
    enable_rise   = 1'b0;
    launch_rise   = 1'b0;
    drive_allowed = 1'b0;
    status0       = 8'h00;
    next_s    = s;
    next_s.move_abort     = 1'b0;
    next_s.move_launch    = 1'b0;
    next_s.setread_launch = 1'b0;
    next_s.fault_clear    = 1'b0;

    // A stray byte outside a started block is dropped; a new first byte restarts.
    if (link.cmd_valid) begin
      if (link.cmd_first) begin
        next_s.rx_buf[7:0] = link.cmd_byte;
        next_s.rx_idx      = 3'h1;
      end else if (s.rx_idx != 3'h0) begin
        // Each byte lands in the slot given by its count, so byte k sits at bits 8k+7:8k.
        next_s.rx_buf[{s.rx_idx, 3'b000} +: 8] = link.cmd_byte;
        next_s.rx_idx = s.rx_idx + 3'h1;
        if (s.rx_idx == servo_block_pkg::LAST_BYTE) begin
          complete = 1'b1;
          nb[63:56] = link.cmd_byte;
        end
      end
    end

    new0 = nb[7:0] & servo_block_pkg::CMD0_WRITABLE;
    if (complete) begin
      // Reserved bits are held as zero, so no stray bit can fake an edge later.
      next_s.held = {nb[63:8], new0};
      clear_req   = new0[servo_block_pkg::BIT_FAULT_CLEAR];
      setread_sel = new0[servo_block_pkg::BIT_BLOCK_SELECT];
      permit_low  = !new0[servo_block_pkg::BIT_HALT_PERMIT];
      // Edges are judged against the held copy, so a block repeated unchanged starts no launch and no drive rise.
      enable_rise = new0[servo_block_pkg::BIT_DRIVE_ENABLE] && !old0[servo_block_pkg::BIT_DRIVE_ENABLE];
      launch_rise = new0[servo_block_pkg::BIT_COMMAND_LAUNCH] && !old0[servo_block_pkg::BIT_COMMAND_LAUNCH];
      next_s.fault_clear = clear_req;
      if (permit_low) begin
        next_s.halted = 1'b1;
        // Entering the halt, normally a 1 to 0 fall, cancels motion.
        next_s.move_abort = !s.halted;
      end else if (s.halted) begin
        next_s.halted     = 1'b0;
        next_s.need_rearm = 1'b1;
      end
      // The rearm flag raised by the release block itself already refuses a rise in that block.
      drive_allowed = !next_s.halted && !next_s.need_rearm && !s.alarm;
      if (!new0[servo_block_pkg::BIT_DRIVE_ENABLE]) begin
        next_s.drive_on   = 1'b0;
        next_s.need_rearm = 1'b0;
      end else if (enable_rise && drive_allowed) begin
        next_s.drive_on = 1'b1;
      end
      if (launch_rise) begin
        // Only bit 7 picks the command family.
        next_s.move_launch    = !setread_sel;
        next_s.setread_launch = setread_sel;
      end
    end

    // Travel stops at once, but the drive stays on to hold the motor until it rests.
    if (next_s.halted && motor_at_rest) begin
      next_s.drive_on = 1'b0;
    end
    // An alarm drops the drive one cycle after it is latched; the rise check refuses it too.
    if (s.alarm) begin
      next_s.drive_on = 1'b0;
    end

    // A fresh event in the clearing cycle survives the clear.
    next_s.alarm = alarm_event | (s.alarm & !clear_req);
    next_s.warn  = warning_event | (s.warn & !clear_req);

    // Response framing; a new block mid-response restarts it with fresh status.
    if (s.tx_busy) begin
      next_s.rsp_valid = 1'b1;
      next_s.rsp_first = (s.tx_idx == 3'h0);
      next_s.rsp_byte  = s.tx_buf[{s.tx_idx, 3'b000} +: 8];
      next_s.tx_idx    = s.tx_idx + 3'h1;
      next_s.tx_busy   = (s.tx_idx != servo_block_pkg::LAST_BYTE);
    end else begin
      next_s.rsp_valid = 1'b0;
      next_s.rsp_first = 1'b0;
      next_s.rsp_byte  = 8'h00;
    end
    if (complete) begin
      next_s.tx_busy = 1'b1;
      next_s.tx_idx  = 3'h0;
      next_s.tx_buf[63:8] = response_data;
      // Status uses the post-block values, so the reply already shows this block's effect.
      status0[7]                                = setread_sel;
      status0[servo_block_pkg::RBIT_READY]      = 1'b1;
      status0[servo_block_pkg::RBIT_MAIN_POWER] = main_power_on;
      status0[servo_block_pkg::RBIT_HALTED]     = next_s.halted;
      status0[servo_block_pkg::RBIT_ALARM]      = next_s.alarm;
      status0[servo_block_pkg::RBIT_WARNING]    = next_s.warn;
      status0[servo_block_pkg::RBIT_DRIVE_ON]   = next_s.drive_on;
      status0[0]                                = new0[servo_block_pkg::BIT_COMMAND_LAUNCH];
      next_s.tx_buf[7:0] = status0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      // The held block resets to zero, so an enable set in the first block counts as a rise.
      s.held <= servo_block_pkg::RST_HELD_BLOCK;
    end else begin
      s <= next_s;
    end
  end

  assign link.rsp_valid      = s.rsp_valid;
  assign link.rsp_first      = s.rsp_first;
  assign link.rsp_byte       = s.rsp_byte;
  assign drive_on            = s.drive_on;
  assign halt_travel         = s.halted;
  assign move_abort          = s.move_abort;
  assign move_launch         = s.move_launch;
  assign setread_launch      = s.setread_launch;
  assign fault_clear_pulse   = s.fault_clear;
  assign data_is_setread     = s.held[servo_block_pkg::BIT_BLOCK_SELECT];
  assign command_data        = s.held[63:8];

endmodule : servo_command_block_decoder

// >>> servo_command_block_decoder_bench.sv
// Testbench joining the controller end and the unit end back to back over the link.
// Assumes software drives the controller over APB and the bench plays the drive-side status.
module servo_command_block_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        motor_at_rest;
  logic        main_power_on;
  logic        alarm_event;
  logic        warning_event;
  logic [55:0] response_data;
  logic        drive_on;
  logic        halt_travel;
  logic        move_abort;
  logic        move_launch;
  logic        setread_launch;
  logic        fault_clear_pulse;
  logic        data_is_setread;
  logic [55:0] command_data;
  logic [64:0] exp_q[$];
  logic [64:0] seen_exp;
  logic [63:0] d;
  logic [63:0] rd;
  logic [7:0]  b0;
  int          bad_count;
  int          cmp_count;
  int          n_move;
  int          n_setread;
  int          n_abort;
  int          n_clear;
  // Each row is the command byte 0 and the response byte 0 expected after it.
  localparam logic [15:0] block_rows [14] = '{16'h1060, 16'h1363, 16'h1363, 16'h92e2, 16'h93e3,
    16'h82f2, 16'h82f0, 16'h92e0, 16'h92e0, 16'h90e0, 16'h92e2, 16'h90c8, 16'h106c, 16'h3060};

  servo_link_if servo_link_if_inst ();
  servo_command_block_decoder servo_command_block_decoder_inst (.clk(clk), .rstn(rstn),
    .link(servo_link_if_inst), .motor_at_rest(motor_at_rest), .main_power_on(main_power_on),
    .alarm_event(alarm_event), .warning_event(warning_event), .response_data(response_data),
    .drive_on(drive_on), .halt_travel(halt_travel), .move_abort(move_abort),
    .move_launch(move_launch), .setread_launch(setread_launch),
    .fault_clear_pulse(fault_clear_pulse), .data_is_setread(data_is_setread),
    .command_data(command_data));
  servo_block_master servo_block_master_inst (.clk(clk), .rstn(rstn), .link(servo_link_if_inst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  servo_link_asserts servo_link_asserts_inst (.clk(clk), .rstn(rstn),
    .cmd_valid(servo_link_if_inst.cmd_valid), .cmd_first(servo_link_if_inst.cmd_first),
    .cmd_byte(servo_link_if_inst.cmd_byte), .rsp_valid(servo_link_if_inst.rsp_valid),
    .rsp_first(servo_link_if_inst.rsp_first), .rsp_byte(servo_link_if_inst.rsp_byte));

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One APB transfer; the expected read data under mask and the error flag go to the queue.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     input logic [31:0] m, input logic [31:0] e, input logic er);
    exp_q.push_back({er, m, e});
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wait_sig(input logic use_irq, input logic want);
    int n;
    n = 0;
    while (((use_irq ? irq : drive_on) !== want) && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(use_irq ? "irq" : "drive_on", want, use_irq ? irq : drive_on);
  endtask : wait_sig

  // Completed transfers, reads and writes, are judged here, apart from the driver, so a late answer is still matched.
  always @(posedge clk) begin
    if (psel && penable && pready && exp_q.size() > 0) begin
      seen_exp = exp_q.pop_front();
      cmp_count++;
      if ((prdata & seen_exp[63:32]) !== seen_exp[31:0] || pslverr !== seen_exp[64]) begin
        bad_count++;
        $display("ERROR apb %h expected %h/%b seen %h/%b", paddr, seen_exp[31:0], seen_exp[64],
                 prdata & seen_exp[63:32], pslverr);
      end
    end
    if (move_launch === 1'b1) n_move++;
    if (setread_launch === 1'b1) n_setread++;
    if (move_abort === 1'b1) n_abort++;
    if (fault_clear_pulse === 1'b1) n_clear++;
  end

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("ERROR watchdog expected finish seen timeout");
    end_sim();
  end

  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    motor_at_rest = 1'b0;
    main_power_on = 1'b1;
    alarm_event = 1'b0;
    warning_event = 1'b0;
    response_data = 56'h0;
    void'($urandom(32'hc17dad7c));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    apb(1'b0, servo_block_pkg::OFF_CMD_CTRL, 32'h0, 32'hffffffff, 32'h10, 1'b0);
    apb(1'b0, servo_block_pkg::OFF_INT_STATUS, 32'h0, 32'hffffffff, 32'h0, 1'b0);
    apb(1'b0, servo_block_pkg::OFF_RSP_LO, 32'h0, 32'hffffffff, 32'h0, 1'b0);
    apb(1'b0, 8'h20, 32'h0, 32'hffffffff, 32'h0, 1'b1);
    apb(1'b1, servo_block_pkg::OFF_RSP_LO, 32'h5, 32'h0, 32'h0, 1'b1);
    apb(1'b1, servo_block_pkg::OFF_CMD_CTRL, 32'hff, 32'h0, 32'h0, 1'b0);
    apb(1'b0, servo_block_pkg::OFF_CMD_CTRL, 32'h0, 32'hffffffff, 32'hb3, 1'b0);
    for (int i = 0; i < 14; i++) begin
      d = {$urandom, $urandom};
      rd = {$urandom, $urandom};
      b0 = block_rows[i][15:8];
      response_data <= rd[55:0];
      main_power_on <= (i != 11);
      if (i == 12) begin
        warning_event <= 1'b1;
        @(posedge clk);
        warning_event <= 1'b0;
      end
      apb(1'b1, servo_block_pkg::OFF_CMD_CTRL, {24'h0, b0}, 32'h0, 32'h0, 1'b0);
      apb(1'b1, servo_block_pkg::OFF_CMD_DATA_LO, d[31:0], 32'h0, 32'h0, 1'b0);
      apb(1'b1, servo_block_pkg::OFF_CMD_DATA_HI, {8'h0, d[55:32]}, 32'h0, 32'h0, 1'b0);
      apb(1'b1, servo_block_pkg::OFF_SEND, 32'h1, 32'h0, 32'h0, 1'b0);
      if (i == 0) begin
        apb(1'b0, servo_block_pkg::OFF_SEND, 32'h0, 32'hffffffff, 32'h1, 1'b0);
        // A block round trip takes under 30 cycles, so a masked irq must stay low.
        repeat (30) @(posedge clk);
        chk("irq masked", 1'b0, irq);
        apb(1'b1, servo_block_pkg::OFF_INT_MASK, 32'h3, 32'h0, 32'h0, 1'b0);
        apb(1'b0, servo_block_pkg::OFF_INT_MASK, 32'h0, 32'hffffffff, 32'h3, 1'b0);
        apb(1'b0, servo_block_pkg::OFF_SEND, 32'h0, 32'hffffffff, 32'h0, 1'b0);
        apb(1'b0, servo_block_pkg::OFF_CMD_DATA_HI, 32'h0, 32'hffffffff, {8'h0, d[55:32]}, 1'b0);
      end
      wait_sig(1'b1, 1'b1);
      apb(1'b0, servo_block_pkg::OFF_INT_STATUS, 32'h0, 32'h3, (i == 5) ? 32'h3 : 32'h1, 1'b0);
      apb(1'b1, servo_block_pkg::OFF_INT_STATUS, 32'h3, 32'h0, 32'h0, 1'b0);
      apb(1'b0, servo_block_pkg::OFF_RSP_LO, 32'h0, 32'hffffffff, {rd[23:0], block_rows[i][7:0]}, 1'b0);
      apb(1'b0, servo_block_pkg::OFF_RSP_HI, 32'h0, 32'hffffffff, rd[55:24], 1'b0);
      chk("command_data", d[55:0], command_data);
      chk("data_is_setread", b0[7], data_is_setread);
      chk("halt_travel", !b0[4], halt_travel);
      if (i == 5) begin
        motor_at_rest <= 1'b1;
        wait_sig(1'b0, 1'b0);
      end
      if (i == 10) begin
        alarm_event <= 1'b1;
        @(posedge clk);
        alarm_event <= 1'b0;
        wait_sig(1'b0, 1'b0);
      end
    end
    apb(1'b0, servo_block_pkg::OFF_CMD_CTRL, 32'h0, 32'hffffffff, 32'h10, 1'b0);
    chk("move launches", 1, n_move);
    chk("setread launches", 1, n_setread);
    chk("move aborts", 1, n_abort);
    chk("fault clears", 1, n_clear);
    end_sim();
  end
endmodule : servo_command_block_decoder_bench

// >>> servo_link_asserts.sv
// Checker for the byte link between the controller end and the servo unit end.
// Assumes it sees the interface signals directly and shares the single bench clock.
module servo_link_asserts (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       cmd_valid,
  input wire logic       cmd_first,
  input wire logic [7:0] cmd_byte,
  input wire logic       rsp_valid,
  input wire logic       rsp_first,
  input wire logic [7:0] rsp_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  cmd_block_len_a: assert property (
    cmd_first |-> cmd_valid ##1 (cmd_valid && !cmd_first)[*7] ##1 !cmd_valid)
    else $error("command block is not eight contiguous bytes");
  rsp_block_len_a: assert property (
    rsp_first |-> rsp_valid ##1 (rsp_valid && !rsp_first)[*7] ##1 !rsp_valid)
    else $error("response block is not eight contiguous bytes");
  rsp_latency_a: assert property (cmd_first |-> ##9 (rsp_valid && rsp_first))
    else $error("response did not start two cycles after the last command byte");
  cmd_reserved_a: assert property (cmd_first |-> (cmd_byte & 8'h4c) == 8'h00)
    else $error("reserved command bits sent as one");
  select_echo_a: assert property (cmd_first |-> ##9 (rsp_byte[7] == $past(cmd_byte[7], 9)))
    else $error("block select not echoed in response");
  halt_flag_a: assert property (cmd_first |-> ##9 (rsp_byte[4] != $past(cmd_byte[4], 9)))
    else $error("halt flag does not mirror the low halt permit");
  launch_echo_a: assert property (cmd_first |-> ##9 (rsp_byte[0] == $past(cmd_byte[0], 9)))
    else $error("launch bit not echoed in response");
  ready_bit_a: assert property (rsp_first |-> rsp_byte[6])
    else $error("ready bit low in response");
  drive_off_a: assert property (cmd_first && !cmd_byte[1] |-> ##9 !rsp_byte[1])
    else $error("drive reported on without enable request");

  cover property (cmd_first && cmd_byte[7]);
  cover property (cmd_first && !cmd_byte[4]);
  cover property (rsp_first && rsp_byte[1]);
endmodule : servo_link_asserts

// >>> servo_link_if.sv
// Byte-serial link between the controller end and the servo unit end.
// Assumes one shared clock; the testbench instantiates and joins both ends.
interface servo_link_if;
  logic       cmd_valid;
  logic       cmd_first;
  logic [7:0] cmd_byte;
  logic       rsp_valid;
  logic       rsp_first;
  logic [7:0] rsp_byte;

  modport unit_end (
    input  cmd_valid,
    input  cmd_first,
    input  cmd_byte,
    output rsp_valid,
    output rsp_first,
    output rsp_byte
  );

  modport master_end (
    output cmd_valid,
    output cmd_first,
    output cmd_byte,
    input  rsp_valid,
    input  rsp_first,
    input  rsp_byte
  );
endinterface : servo_link_if
